// ===== core/mds_pkg.sv
// Constants and carrier types shared by the motor driver I/O status block.
// Assumes one 125 MHz system clock for all logic.
package mds_pkg;
	localparam int CLK_PERIOD_NS = 8;
	localparam int SPEED_PULSE_NS = 200000;
	localparam int SPEED_PULSE_CYC = SPEED_PULSE_NS / CLK_PERIOD_NS;
	localparam int PULSES_PER_REV = 30;
	localparam int DEBOUNCE_NS = 1000000;
	localparam int DEBOUNCE_CYC = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BLINK_NS = 250000000;
	localparam int BLINK_CYC = BLINK_NS / CLK_PERIOD_NS;
	localparam int N_TERM = 8;
	localparam int N_CLASS = 14;
	localparam int N_IRQ = 3;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ASSIGN = 8'h04;
	localparam logic [7:0] REG_NOTICE_EN = 8'h08;
	localparam logic [7:0] REG_NOTICE_STAT = 8'h0C;
	localparam logic [7:0] REG_NOTICE_RAW = 8'h10;
	localparam logic [7:0] REG_STATUS = 8'h14;
	localparam logic [7:0] REG_IRQ_STAT = 8'h18;
	localparam logic [7:0] REG_IRQ_MASK = 8'h1C;
	localparam int CTRL_AUTO_CLR = 0;
	localparam int CTRL_ALARM_RST = 1;
	localparam logic CTRL_AUTO_CLR_RESET = 1'h0;
	localparam int ASG_LOCK_LSB = 0;
	localparam int ASG_TORQUE_LSB = 8;
	localparam int ASG_FAULT_LSB = 16;
	localparam int ASG_CLEAR_LSB = 24;
	localparam logic [31:0] ASSIGN_RESET = 32'h0000_0000;
	localparam logic [N_CLASS-1:0] NOTICE_EN_RESET = 14'h3FFF;
	localparam int IRQ_ALARM = 0;
	localparam int IRQ_NOTICE = 1;
	localparam int IRQ_CLEARED = 2;
	localparam int STAT_ALARM = 0;
	localparam int STAT_ALARM_EXT = 1;
	localparam int STAT_LOCK = 2;
	localparam int STAT_TORQUE = 3;
	localparam int STAT_FAULT_OK = 4;
	localparam int STAT_MOVING = 5;
	localparam int STAT_NOTICE = 6;
	localparam int STAT_CODE_LSB = 8;
	localparam int STAT_TERM_LSB = 16;
	// Arbitrary display code for the external-fault alarm
	localparam logic [7:0] EXT_FAULT_CODE = 8'h6E;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} mds_wb_req_t;

	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} mds_wb_rsp_t;

	// One bit per blocked panel or tool function, high while blocked
	typedef struct packed {
		logic io_test;
		logic local_op;
		logic teach_remote;
		logic edit;
		logic download;
		logic init;
		logic config_fn;
	} mds_restrict_t;
endpackage

// ===== core/mds_debounce.sv
// Two-flop synchroniser and stability debouncer for one terminal input.
// Assumes raw_i is asynchronous to sys_clk_i.
`timescale 1ns/1ps
module mds_debounce #(
	parameter int CYC = mds_pkg::DEBOUNCE_CYC
)
(
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	input wire logic raw_i,
	output logic clean_o
);
	import mds_pkg::*;
	localparam int CW = $clog2(CYC + 1);

	typedef struct packed {
		logic s1;
		logic s2;
		logic clean;
		logic [CW-1:0] cnt;
	} mds_deb_state_t;

	mds_deb_state_t st_reg;
	mds_deb_state_t st_next;

	if (CYC < 1)
	begin : g_chk
		$error("mds_debounce: CYC must be at least 1");
	end

	always_comb
	begin
		st_next = st_reg;
		st_next.s1 = raw_i;
		st_next.s2 = st_reg.s1;
		if (st_reg.s2 == st_reg.clean)
			st_next.cnt = '0;
		else if (st_reg.cnt == CW'(CYC - 1))
		begin
			st_next.cnt = '0;
			st_next.clean = st_reg.s2;
		end
		else
			st_next.cnt = CW'(st_reg.cnt + 1'h1);
	end

	// Terminals start closed so no false alarm or clear edge after reset
	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			st_reg <= '0;
			st_reg.s1 <= 1'h1;
			st_reg.s2 <= 1'h1;
			st_reg.clean <= 1'h1;
		end
		else
			st_reg <= st_next;
	end

	assign clean_o = st_reg.clean;

	deb_settle_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
		$changed(clean_o) |-> $past(st_reg.cnt) == CW'(CYC - 1) && clean_o == $past(st_reg.s2))
		else $error("Debounced level changed before the input was stable");
endmodule

// ===== core/mds_speed_pulse.sv
// Fixed-width speed pulse generator, one pulse per rotation tick that arrives while no pulse is running.
// Assumes tick_i is a one-cycle pulse every 1/30 shaft revolution.
`timescale 1ns/1ps
module mds_speed_pulse #(
	parameter int WIDTH_CYC = mds_pkg::SPEED_PULSE_CYC
)
(
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	input wire logic tick_i,
	output logic pulse_o
);
	import mds_pkg::*;
	localparam int CW = $clog2(WIDTH_CYC + 1);

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic pulse;
	} mds_pls_state_t;

	mds_pls_state_t st_reg;
	mds_pls_state_t st_next;

	if (WIDTH_CYC < 1)
	begin : g_chk
		$error("mds_speed_pulse: WIDTH_CYC must be at least 1");
	end

	// Ticks during a pulse are dropped; only beyond pulse-width overlap speeds
	always_comb
	begin
		st_next = st_reg;
		if (st_reg.cnt != '0)
			st_next.cnt = CW'(st_reg.cnt - 1'h1);
		else if (tick_i)
			st_next.cnt = CW'(WIDTH_CYC);
		st_next.pulse = st_next.cnt != '0;
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign pulse_o = st_reg.pulse;

	tick_start_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
		tick_i && !pulse_o |=> pulse_o && st_reg.cnt == CW'(WIDTH_CYC))
		else $error("Rotation tick did not start a speed pulse");
	width_end_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
		pulse_o && st_reg.cnt == CW'(1) |=> !pulse_o)
		else $error("Speed pulse did not end after its fixed width");
endmodule

// ===== core/mds_top.sv
// Motor driver terminal input decoding, alarm, notice and speed pulse outputs.
// Assumes terminals are asynchronous pins; motor and protection inputs share sys_clk_i.
// Class order, bit 0 up: drive temperature, overvoltage, undervoltage, load, speed,
// operation prohibited, trip distance, total distance, power time, power count,
// start restricted, io test mode, config request, power cycle request.
`timescale 1ns/1ps
module mds_top #(
	parameter int DEBOUNCE_CYC = mds_pkg::DEBOUNCE_CYC,
	parameter int SPEED_PULSE_CYC = mds_pkg::SPEED_PULSE_CYC,
	parameter int BLINK_CYC = mds_pkg::BLINK_CYC,
	parameter logic [7:0] EXT_FAULT_CODE = mds_pkg::EXT_FAULT_CODE
)
(
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	input wire mds_pkg::mds_wb_req_t wb_i,
	output mds_pkg::mds_wb_rsp_t wb_o,
	input wire logic [mds_pkg::N_TERM-1:0] term_i,
	input wire logic [mds_pkg::N_CLASS-1:0] notice_cond_i,
	input wire logic protect_trip_i,
	input wire logic [7:0] protect_code_i,
	input wire logic run_cmd_i,
	input wire logic motor_rotating_i,
	input wire logic rot_tick_i,
	output logic alarm_out_o,
	output logic alarm_led_o,
	output logic [7:0] alarm_code_o,
	output logic motor_stop_instant_o,
	output logic motor_coast_o,
	output mds_pkg::mds_restrict_t panel_restrict_o,
	output logic torque_limit_en_o,
	output logic moving_o,
	output logic notice_out_o,
	output logic notice_led_o,
	output logic speed_pulse_o,
	output logic irq_o
);
	import mds_pkg::*;
	localparam int BW = $clog2(BLINK_CYC + 1);

	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
		logic auto_clr;
		logic [31:0] asg;
		logic [N_CLASS-1:0] notice_en;
		logic [N_CLASS-1:0] pend;
		logic [N_IRQ-1:0] irq_stat;
		logic [N_IRQ-1:0] irq_mask;
		logic clr_prev;
		logic alarm;
		logic alarm_ext;
		logic [7:0] code;
		logic [BW-1:0] blink_cnt;
		logic blink;
		mds_restrict_t restr;
		logic torque_en;
		logic moving;
		logic notice_out;
		logic alarm_led;
		logic notice_led;
	} mds_state_t;

	mds_state_t st_reg;
	mds_state_t st_next;
	logic [N_TERM-1:0] term_clean;
	logic lock_act;
	logic torque_act;
	logic fault_act;
	logic clr_act;
	logic req;
	logic wr;
	logic rd;
	logic clr_evt;
	logic alarm_rst;
	logic [N_IRQ-1:0] irq_ev;

	if (BLINK_CYC < 2)
	begin : g_chk
		$error("mds_top: BLINK_CYC must be at least 2");
	end

	if (PULSES_PER_REV != 30)
	begin : g_chk_rev
		$error("mds_top: rotation ticks must come 30 per revolution");
	end

	// Unassigned terminal map falls back to dflt
	function automatic logic func_level(input logic [N_TERM-1:0] m, input logic [N_TERM-1:0] t,
		input logic dflt);
		func_level = (m == '0) ? dflt : &(t | ~m);
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
		input logic [3:0] sel);
		logic [31:0] m;
		m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
		merge = (old & ~m) | (dat & m);
	endfunction

	for (genvar i = 0; i < N_TERM; i++)
	begin : g_term
		mds_debounce #(
			.CYC(DEBOUNCE_CYC)
		) u_deb (
			.sys_clk_i(sys_clk_i),
			.resetn_i(resetn_i),
			.raw_i(term_i[i]),
			.clean_o(term_clean[i])
		);
	end

	mds_speed_pulse #(
		.WIDTH_CYC(SPEED_PULSE_CYC)
	) u_pulse (
		.sys_clk_i(sys_clk_i),
		.resetn_i(resetn_i),
		.tick_i(rot_tick_i),
		.pulse_o(speed_pulse_o)
	);

	// Lock, torque and fault default closed; clear defaults open
	assign lock_act = func_level(st_reg.asg[ASG_LOCK_LSB +: N_TERM], term_clean, 1'h1);
	assign torque_act = func_level(st_reg.asg[ASG_TORQUE_LSB +: N_TERM], term_clean, 1'h1);
	assign fault_act = func_level(st_reg.asg[ASG_FAULT_LSB +: N_TERM], term_clean, 1'h1);
	assign clr_act = func_level(st_reg.asg[ASG_CLEAR_LSB +: N_TERM], term_clean, 1'h0);

	assign req = wb_i.cyc & wb_i.stb & ~st_reg.ack;
	assign wr = req & wb_i.we;
	assign rd = req & ~wb_i.we;
	assign clr_evt = clr_act & ~st_reg.clr_prev & ~st_reg.auto_clr;
	assign alarm_rst = wr && wb_i.adr == REG_CTRL && wb_i.sel[0] && wb_i.dat[CTRL_ALARM_RST];

	always_comb
	begin
		st_next = st_reg;
		st_next.ack = req;
		st_next.clr_prev = clr_act;

		if (wr)
		begin
			case (wb_i.adr)
				REG_CTRL:
				begin
					if (wb_i.sel[0])
						st_next.auto_clr = wb_i.dat[CTRL_AUTO_CLR];
				end
				REG_ASSIGN:
					st_next.asg = merge(st_reg.asg, wb_i.dat, wb_i.sel);
				REG_NOTICE_EN:
					st_next.notice_en = N_CLASS'(merge(32'(st_reg.notice_en), wb_i.dat, wb_i.sel));
				REG_IRQ_MASK:
				begin
					if (wb_i.sel[0])
						st_next.irq_mask = wb_i.dat[N_IRQ-1:0];
				end
				default:
				begin
				end
			endcase
		end

		// Pending bits follow conditions regardless of the action setting
		if (st_reg.auto_clr)
			st_next.pend = notice_cond_i;
		else
			st_next.pend = (st_reg.pend & ~{N_CLASS{clr_evt}}) | notice_cond_i;

		// First cause wins; reset refused while any cause persists
		if (!st_reg.alarm && !fault_act)
		begin
			st_next.alarm = 1'h1;
			st_next.alarm_ext = 1'h1;
			st_next.code = EXT_FAULT_CODE;
		end
		else if (!st_reg.alarm && protect_trip_i)
		begin
			st_next.alarm = 1'h1;
			st_next.alarm_ext = 1'h0;
			st_next.code = protect_code_i;
		end
		else if (alarm_rst && fault_act && !protect_trip_i)
		begin
			st_next.alarm = 1'h0;
			st_next.alarm_ext = 1'h0;
		end

		irq_ev = '0;
		irq_ev[IRQ_ALARM] = st_next.alarm & ~st_reg.alarm;
		irq_ev[IRQ_NOTICE] = |(st_next.pend & ~st_reg.pend);
		irq_ev[IRQ_CLEARED] = clr_evt;
		if (wr && wb_i.adr == REG_IRQ_STAT && wb_i.sel[0])
			st_next.irq_stat = st_reg.irq_stat & ~wb_i.dat[N_IRQ-1:0];
		// A new event wins over a clear in the same cycle
		st_next.irq_stat = st_next.irq_stat | irq_ev;

		if (st_reg.blink_cnt == BW'(BLINK_CYC - 1))
		begin
			st_next.blink_cnt = '0;
			st_next.blink = ~st_reg.blink;
		end
		else
			st_next.blink_cnt = BW'(st_reg.blink_cnt + 1'h1);

		st_next.restr = {$bits(mds_restrict_t){~lock_act}};
		st_next.torque_en = torque_act;
		st_next.moving = motor_rotating_i & run_cmd_i;
		st_next.notice_out = |(st_reg.pend & st_reg.notice_en);
		st_next.notice_led = st_next.notice_out & st_reg.blink;
		st_next.alarm_led = st_reg.alarm & st_reg.blink;

		st_next.rdata = '0;
		if (rd)
		begin
			case (wb_i.adr)
				REG_CTRL:
					st_next.rdata[CTRL_AUTO_CLR] = st_reg.auto_clr;
				REG_ASSIGN:
					st_next.rdata = st_reg.asg;
				REG_NOTICE_EN:
					st_next.rdata[N_CLASS-1:0] = st_reg.notice_en;
				REG_NOTICE_STAT:
					st_next.rdata[N_CLASS-1:0] = st_reg.pend;
				REG_NOTICE_RAW:
					st_next.rdata[N_CLASS-1:0] = notice_cond_i;
				REG_STATUS:
				begin
					st_next.rdata[STAT_ALARM] = st_reg.alarm;
					st_next.rdata[STAT_ALARM_EXT] = st_reg.alarm_ext;
					st_next.rdata[STAT_LOCK] = lock_act;
					st_next.rdata[STAT_TORQUE] = torque_act;
					st_next.rdata[STAT_FAULT_OK] = fault_act;
					st_next.rdata[STAT_MOVING] = st_reg.moving;
					st_next.rdata[STAT_NOTICE] = st_reg.notice_out;
					st_next.rdata[STAT_CODE_LSB +: 8] = st_reg.code;
					st_next.rdata[STAT_TERM_LSB +: N_TERM] = term_clean;
				end
				REG_IRQ_STAT:
					st_next.rdata[N_IRQ-1:0] = st_reg.irq_stat;
				REG_IRQ_MASK:
					st_next.rdata[N_IRQ-1:0] = st_reg.irq_mask;
				default:
					st_next.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			st_reg <= '0;
			st_reg.auto_clr <= CTRL_AUTO_CLR_RESET;
			st_reg.asg <= ASSIGN_RESET;
			st_reg.notice_en <= NOTICE_EN_RESET;
			// Unassigned torque input reads closed, so limiting starts enabled
			st_reg.torque_en <= 1'h1;
		end
		else
			st_reg <= st_next;
	end

	assign wb_o = '{ack: st_reg.ack, dat: st_reg.rdata};
	assign alarm_out_o = ~st_reg.alarm;
	assign alarm_led_o = st_reg.alarm_led;
	assign alarm_code_o = st_reg.code;
	assign motor_stop_instant_o = st_reg.alarm & st_reg.alarm_ext;
	assign motor_coast_o = st_reg.alarm & ~st_reg.alarm_ext;
	assign panel_restrict_o = st_reg.restr;
	assign torque_limit_en_o = st_reg.torque_en;
	assign moving_o = st_reg.moving;
	assign notice_out_o = st_reg.notice_out;
	assign notice_led_o = st_reg.notice_led;
	assign irq_o = |(st_reg.irq_stat & st_reg.irq_mask);

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!resetn_i);

	clear_edge_a: assert property (clr_evt |=> (st_reg.pend & ~$past(notice_cond_i)) == '0)
		else $error("Clear edge left a stale pending notice");
	auto_ignore_a: assert property (st_reg.auto_clr && clr_act |=> st_reg.pend == $past(notice_cond_i))
		else $error("Clear input acted while auto clear enabled");
	lock_restrict_a: assert property (##1 panel_restrict_o == {7{~$past(lock_act)}})
		else $error("Panel restrictions disagree with operator lock");
	fault_stop_a: assert property (!fault_act && !st_reg.alarm |=>
		motor_stop_instant_o && !motor_coast_o && !alarm_out_o && alarm_code_o == EXT_FAULT_CODE)
		else $error("External fault did not stop the motor instantly");
	unassigned_on_a: assert property (st_reg.asg[ASG_TORQUE_LSB +: N_TERM] == '0 |=> torque_limit_en_o)
		else $error("Unassigned torque limit input not treated as closed");
	all_closed_a: assert property (torque_limit_en_o && $past(st_reg.asg[ASG_TORQUE_LSB +: N_TERM]) != '0 |->
		($past(term_clean) & $past(st_reg.asg[ASG_TORQUE_LSB +: N_TERM])) == $past(st_reg.asg[ASG_TORQUE_LSB +: N_TERM]))
		else $error("Function active with an assigned terminal open");
	trip_coast_a: assert property (protect_trip_i && fault_act && !st_reg.alarm |=>
		!alarm_out_o && motor_coast_o && alarm_code_o == $past(protect_code_i))
		else $error("Protective trip did not open alarm output and coast");
	moving_on_a: assert property (motor_rotating_i && run_cmd_i |=> moving_o)
		else $error("Moving output missing while rotating under command");
	notice_mask_a: assert property (notice_out_o |-> ($past(st_reg.pend) & $past(st_reg.notice_en)) != '0)
		else $error("Notice output set without an enabled pending class");
	notice_led_a: assert property (notice_led_o |-> notice_out_o)
		else $error("Notice LED lit while notice output is off");
	status_keep_a: assert property (##1 (st_reg.pend & $past(notice_cond_i)) == $past(notice_cond_i))
		else $error("Notice status bit did not follow its condition");
	torque_follow_a: assert property (!torque_act |=> !torque_limit_en_o)
		else $error("Torque limiting stayed on with input open");

	// Bus answer is one registered pulse; data reads zero outside it
	ack_pulse_a: assert property (wb_o.ack |=> !wb_o.ack)
		else $error("Bus acknowledge held for more than one cycle");
	rdata_idle_a: assert property (!wb_o.ack |-> wb_o.dat == '0)
		else $error("Read data not zero outside acknowledge");

	clear_level_a: assert property (clr_act && st_reg.clr_prev && !st_reg.auto_clr |=>
		(st_reg.pend & $past(st_reg.pend)) == $past(st_reg.pend))
		else $error("Held clear level removed a pending notice");
	clear_irq_a: assert property (clr_evt |=> st_reg.irq_stat[IRQ_CLEARED])
		else $error("Clear edge did not set its interrupt status");
	alarm_hold_a: assert property (st_reg.alarm && !fault_act |=> st_reg.alarm)
		else $error("Alarm dropped while external fault still open");
	code_hold_a: assert property (st_reg.alarm |=> alarm_code_o == $past(alarm_code_o))
		else $error("Alarm code changed while alarm active");
	alarm_led_a: assert property (alarm_led_o |-> $past(st_reg.alarm))
		else $error("Alarm LED lit without an alarm");
	moving_off_a: assert property (!(motor_rotating_i && run_cmd_i) |=> !moving_o)
		else $error("Moving output on without rotation under command");
endmodule

// ===== dv/mds_ctrl_model.sv
// External controller model: terminal contacts and motor feedback.
// Assumes bench commands change just after rising edges of sys_clk_i.
`timescale 1ns/1ps
module mds_ctrl_model
(
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	input wire logic [7:0] term_cmd_i,
	input wire logic spin_i,
	input wire logic [7:0] gap_i,
	output logic [7:0] term_o,
	output logic rotating_o,
	output logic rot_tick_o
);
	logic [7:0] cnt_reg;

	// Contacts rest closed, as normally closed wiring would
	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			term_o <= 8'hFF;
			rotating_o <= 1'b0;
			rot_tick_o <= 1'b0;
			cnt_reg <= 8'h00;
		end
		else
		begin
			term_o <= term_cmd_i;
			rotating_o <= spin_i;
			// One tick per 1/30 revolution; gap sets the speed
			rot_tick_o <= spin_i && (cnt_reg == gap_i - 8'h01);
			cnt_reg <= (!spin_i || cnt_reg == gap_i - 8'h01) ? 8'h00 : cnt_reg + 8'h01;
		end
	end
endmodule

// ===== dv/mds_top_bench.sv
// Self-checking bench for mds_top: Wishbone register tasks and pin scenarios.
// Assumes short debounce, pulse and blink parameters to keep the run brief.
`timescale 1ns/1ps
module mds_top_bench;
	import mds_pkg::*;
	localparam int DB = 4;
	localparam int SP = 5;
	logic sys_clk_i = 1'b0;
	logic resetn_i = 1'b0;
	mds_wb_req_t wb_i = '0;
	mds_wb_rsp_t wb_o;
	logic [7:0] term_cmd = 8'hFF;
	logic [7:0] term;
	logic [13:0] cond = '0;
	logic trip = 1'b0;
	logic run = 1'b0;
	logic spin = 1'b0;
	logic [7:0] gap = 8'h0C;
	logic rotating;
	logic tick;
	logic alarm_out;
	logic alarm_led;
	logic [7:0] alarm_code;
	logic stop_inst;
	logic coast;
	mds_restrict_t restr;
	logic tq_en;
	logic moving;
	logic notice_out;
	logic notice_led;
	logic spd;
	logic irq;
	logic seen;
	logic [31:0] rd;
	int fails = 0;
	int checked = 0;
	int hi = 0;
	int rises = 0;
	int ticks = 0;

	always #4 sys_clk_i = ~sys_clk_i;

	mds_ctrl_model far_end (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .term_cmd_i(term_cmd), .spin_i(spin),
		.gap_i(gap), .term_o(term), .rotating_o(rotating), .rot_tick_o(tick));

	mds_top #(.DEBOUNCE_CYC(DB), .SPEED_PULSE_CYC(SP), .BLINK_CYC(4)) dut (.sys_clk_i(sys_clk_i),
		.resetn_i(resetn_i), .wb_i(wb_i), .wb_o(wb_o), .term_i(term), .notice_cond_i(cond),
		.protect_trip_i(trip), .protect_code_i(8'h2A), .run_cmd_i(run), .motor_rotating_i(rotating),
		.rot_tick_i(tick), .alarm_out_o(alarm_out), .alarm_led_o(alarm_led), .alarm_code_o(alarm_code),
		.motor_stop_instant_o(stop_inst), .motor_coast_o(coast), .panel_restrict_o(restr),
		.torque_limit_en_o(tq_en), .moving_o(moving), .notice_out_o(notice_out), .notice_led_o(notice_led),
		.speed_pulse_o(spd), .irq_o(irq));

	task automatic wrap_up();
		if (fails == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask

	// Classic cycle: held until ack is sampled high, then released
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		int n;
		n = 0;
		@(posedge sys_clk_i);
		wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: dat};
		do
		begin
			@(posedge sys_clk_i);
			n++;
		end
		while (wb_o.ack !== 1'b1 && n < 50);
		if (n >= 50)
		begin
			fails++;
			wrap_up();
		end
		rd = wb_o.dat;
		wb_i <= '0;
	endtask

	task automatic rchk(input logic [7:0] adr, input logic [31:0] exp);
		wb(1'b0, adr, 32'h0);
		chk(rd, exp);
	endtask

	// Terminal changes need the sync and debounce delay to show
	task automatic set_term(input logic [7:0] v);
		@(posedge sys_clk_i);
		term_cmd <= v;
		wait_cyc(DB + 6);
	endtask

	always @(posedge sys_clk_i)
	begin
		if (tick)
			ticks++;
		if (spd && hi == 0)
			rises++;
		if (spd)
			hi++;
		else if (hi != 0)
		begin
			chk(hi, SP);
			hi = 0;
		end
	end

	initial
	begin
		repeat (20000) @(posedge sys_clk_i);
		fails++;
		wrap_up();
	end

	initial
	begin
		repeat (12) @(posedge sys_clk_i);
		resetn_i <= 1'b1;
		wait_cyc(2);
		chk(alarm_out, 1'b1);
		chk(restr, 32'h0);
		chk(tq_en, 1'b1);
		rchk(REG_NOTICE_EN, 32'h3FFF);
		rchk(REG_CTRL, 32'h0);
		rchk(REG_STATUS, 32'h00FF_001C);
		wb(1'b1, 8'h40, 32'hFFFF_FFFF);
		rchk(8'h40, 32'h0);
		// Lock on terminals 0 and 1, torque 2, clear 3, fault 4
		wb(1'b1, REG_ASSIGN, 32'h0810_0403);
		rchk(REG_ASSIGN, 32'h0810_0403);
		set_term(8'hFD);
		chk(restr, 32'h7F);
		set_term(8'hFF);
		chk(restr, 32'h0);
		set_term(8'hFB);
		chk(tq_en, 1'b0);
		set_term(8'hFF);
		chk(tq_en, 1'b1);
		for (int i = 0; i < N_CLASS; i++)
		begin
			wb(1'b1, REG_NOTICE_EN, ~(32'h1 << i));
			@(posedge sys_clk_i);
			cond <= 14'h1 << i;
			wait_cyc(3);
			chk(notice_out, 1'b0);
			chk(notice_led, 1'b0);
			rchk(REG_NOTICE_STAT, 32'h1 << i);
			wb(1'b1, REG_NOTICE_EN, 32'h3FFF);
			wait_cyc(3);
			chk(notice_out, 1'b1);
			seen = 1'b0;
			repeat (8)
			begin
				wait_cyc(1);
				seen = seen | notice_led;
			end
			chk(seen, 1'b1);
			@(posedge sys_clk_i);
			cond <= '0;
			set_term(8'hF7);
			rchk(REG_NOTICE_STAT, 32'h1 << i);
			set_term(8'hFF);
			rchk(REG_NOTICE_STAT, 32'h0);
		end
		// Clear held closed: level alone must not clear
		@(posedge sys_clk_i);
		cond <= 14'h0001;
		wait_cyc(3);
		@(posedge sys_clk_i);
		cond <= 14'h0000;
		wait_cyc(3);
		rchk(REG_NOTICE_STAT, 32'h1);
		wb(1'b1, REG_IRQ_STAT, 32'h7);
		wb(1'b1, REG_IRQ_MASK, 32'h4);
		set_term(8'hF7);
		set_term(8'hFF);
		chk(irq, 1'b1);
		rchk(REG_IRQ_STAT, 32'h4);
		rchk(REG_NOTICE_STAT, 32'h0);
		wb(1'b1, REG_IRQ_STAT, 32'h4);
		wait_cyc(2);
		chk(irq, 1'b0);
		wb(1'b1, REG_CTRL, 32'h1);
		set_term(8'hF7);
		set_term(8'hFF);
		rchk(REG_IRQ_STAT, 32'h0);
		wb(1'b1, REG_CTRL, 32'h0);
		wb(1'b1, REG_IRQ_MASK, 32'h0);
		set_term(8'hEF);
		chk(alarm_out, 1'b0);
		chk(stop_inst, 1'b1);
		chk(coast, 1'b0);
		chk(alarm_code, EXT_FAULT_CODE);
		chk(irq, 1'b0);
		seen = 1'b0;
		repeat (12)
		begin
			wait_cyc(1);
			seen = seen | alarm_led;
		end
		chk(seen, 1'b1);
		wb(1'b1, REG_CTRL, 32'h2);
		wait_cyc(2);
		chk(alarm_out, 1'b0);
		set_term(8'hFF);
		wb(1'b1, REG_CTRL, 32'h2);
		wait_cyc(2);
		chk(alarm_out, 1'b1);
		wb(1'b1, REG_IRQ_MASK, 32'h1);
		wait_cyc(2);
		chk(irq, 1'b1);
		wb(1'b1, REG_IRQ_STAT, 32'h1);
		wait_cyc(2);
		chk(irq, 1'b0);
		@(posedge sys_clk_i);
		trip <= 1'b1;
		wait_cyc(3);
		chk(alarm_out, 1'b0);
		chk(coast, 1'b1);
		chk(stop_inst, 1'b0);
		chk(alarm_code, 8'h2A);
		@(posedge sys_clk_i);
		trip <= 1'b0;
		wb(1'b1, REG_CTRL, 32'h2);
		wait_cyc(2);
		chk(alarm_out, 1'b1);
		for (int k = 0; k < 4; k++)
		begin
			@(posedge sys_clk_i);
			run <= k[0];
			spin <= k[1];
			wait_cyc(4);
			chk(moving, k[0] & k[1]);
		end
		@(posedge sys_clk_i);
		spin <= 1'b0;
		wait_cyc(20);
		ticks = 0;
		rises = 0;
		@(posedge sys_clk_i);
		spin <= 1'b1;
		wait_cyc(300);
		@(posedge sys_clk_i);
		gap <= 8'h28;
		wait_cyc(300);
		@(posedge sys_clk_i);
		spin <= 1'b0;
		wait_cyc(20);
		chk(rises, ticks);
		chk(ticks > 25, 1'b1);
		wrap_up();
	end
endmodule
